// ### hdl/sbcw_pkg.sv
/* Constants, register layout and state codes of both ends.
   Assumes one 25 MHz clock shared by both ends. */
//
// Contract
// R01: LIN driver off on faults, resume when recessive
// R02: reset low while cause lasts, then 1.0 ms
// R03: regulator output below threshold issues a reset
// R04: regulator overheat disables it, sets flag
// R05: badly serviced watchdog resets the controller
// R06: external low reset holds safe state
// R07: no stretch after external reset release
// R08: stop wake interrupts, sleep wake runs reset
// R09: wake input enable bit, readable input state
// R10: wake input in multiplexer disables its wake
// R11: cyclic sense pulses switches, wakes on change
// R12: cyclic sense and forced wake are exclusive
// R13: controller configures cyclic sense before command
// R14: forced wake uses period, switches all off
// R15: chip select rise wakes stop, unreported
// R16: LIN wake needs long dominant then recessive
// R17: receive-only bit blocks LIN wake in stop
// R18: reset pin low in stop wakes, unreported
// R19: mode write clears watchdog, closed half fails
// R20: grounded config pin disables watchdog, sampled in reset
// R21: open config pin uses 150 ms fallback, flagged
// R22: prescaler divides timebase; 150 ms request timeout
// R23: controller writes normal mode within 150 ms
// R24: interrupt low until source register read
package sbcw_pkg;
	// cycle counts at the 40 ns pclk
	localparam int RST_STRETCH_CYC    = 25000;
	localparam int NREQ_TIMEOUT_CYC   = 3750000;
	localparam int WD_FALLBACK_CYC    = 3750000;
	localparam int WD_RES_TIMEOUT_CYC = 2500000;
	localparam int RST_FILTER_CYC     = 50;
	localparam int WAKE_PULSE_MIN_CYC = 1250;
	localparam int LP_PERIOD_BASE_CYC = 250000;
	localparam int SENSE_ON_CYC       = 2500;

	// device register indices
	localparam logic [3:0] REG_MODE_CTRL  = 4'h0;
	localparam logic [3:0] REG_WAKE_CTRL  = 4'h1;
	localparam logic [3:0] REG_WAKE_STAT  = 4'h2;
	localparam logic [3:0] REG_HS_CTRL    = 4'h3;
	localparam logic [3:0] REG_TIM_CTRL   = 4'h4;
	localparam logic [3:0] REG_LIN_CTRL   = 4'h5;
	localparam logic [3:0] REG_WD_STAT    = 4'h6;
	localparam logic [3:0] REG_INT_SRC    = 4'h7;
	localparam logic [3:0] REG_SUPPLY     = 4'h8;

	localparam int TIM_PRESC_LSB   = 0;
	localparam int TIM_PERIOD_LSB  = 2;
	localparam int TIM_SEL_BIT     = 4;
	localparam int ISR_WAKE_IN     = 0;
	localparam int ISR_LIN_WAKE    = 1;
	localparam int ISR_TIMER       = 2;
	localparam int ISR_LIN_FAULT   = 3;
	localparam logic [4:0] TIM_RST = 5'h00;
	localparam logic [1:0] HS_RST  = 2'h0;

	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_SLEEP  = 2'h1;
	localparam logic [1:0] MODE_STOP   = 2'h2;

	localparam logic [1:0] WDCFG_OPEN  = 2'h0;
	localparam logic [1:0] WDCFG_RES   = 2'h1;
	localparam logic [1:0] WDCFG_GND   = 2'h2;

	// host end APB map
	localparam logic [11:0] HOST_CMD    = 12'h000;
	localparam logic [11:0] HOST_WDATA  = 12'h004;
	localparam logic [11:0] HOST_RDATA  = 12'h008;
	localparam logic [11:0] HOST_STATUS = 12'h00c;
	localparam logic [11:0] HOST_CTRL   = 12'h010;
	localparam int CMD_WE_BIT = 8;
	localparam int CMD_GO_BIT = 31;

	typedef enum logic [4:0] {
		ST_RESET  = 5'b00001,
		ST_NREQ   = 5'b00010,
		ST_NORMAL = 5'b00100,
		ST_STOP   = 5'b01000,
		ST_SLEEP  = 5'b10000
	} sbcw_state_t;

	// timebase scaled by a two-bit power of two
	function automatic logic [31:0] sbcw_scale(input int base,
		input logic [1:0] sh);
		return 32'(base) << sh;
	endfunction : sbcw_scale
endpackage : sbcw_pkg

// ### hdl/sbcw_if.sv
/* Pins between control block and host: reset line, irq, register link.
   Assumes both ends run on one clock. */
interface sbcw_if;
	logic       dev_rst_o;
	logic       dev_rst_oe;
	logic       host_rst_o;
	logic       host_rst_oe;
	logic       rst_i;
	logic       irq_n;
	logic       cs_n;
	logic       req;
	logic       we;
	logic [3:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic       ack;

	// wired-and of the two open-drain drivers
	assign rst_i = ~((dev_rst_oe & ~dev_rst_o) |
		(host_rst_oe & ~host_rst_o));

	modport dev (input rst_i, cs_n, req, we, addr, wdata,
		output dev_rst_o, dev_rst_oe, irq_n, rdata, ack);
	modport host (input rst_i, irq_n, rdata, ack,
		output host_rst_o, host_rst_oe, cs_n, req, we, addr, wdata);
endinterface : sbcw_if

// ### hdl/sbcw_glitch_filter.sv
/* Reset line glitch filter: low after a run of low samples, high at once.
   Assumes a pclk-synchronous input. */
module sbcw_glitch_filter import sbcw_pkg::*; #(
	parameter int FILT_CYC = RST_FILTER_CYC
) (
	input  wire logic pclk,       // clock
	input  wire logic presetn,    // async reset, low
	input  wire logic ce,         // clock enable
	input  wire logic raw_low,    // unfiltered low request
	output logic      filt_low_q  // filtered low
);
	logic [15:0] cnt_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q      <= 16'h0000;
			filt_low_q <= 1'b0;
		end else if (ce) begin
			if (!raw_low) begin
				cnt_q      <= 16'h0000;
				filt_low_q <= 1'b0;
			end else if (cnt_q >= 16'(FILT_CYC - 1)) begin
				filt_low_q <= 1'b1;
			end else begin
				cnt_q <= cnt_q + 16'h0001;
			end
		end
	end
endmodule : sbcw_glitch_filter

// ### hdl/sbcw_device.sv
/* Reset, wake-up and window watchdog control of the basis chip.
   Assumes pins synchronous to pclk and a host keeping the handshake. */
// Decided for this implementation: the req/ack register link handshake and the register indices.
module sbcw_device import sbcw_pkg::*; #(
	parameter int STRETCH_CYC = RST_STRETCH_CYC,
	parameter int NREQ_CYC    = NREQ_TIMEOUT_CYC,
	parameter int WD_RES_CYC  = WD_RES_TIMEOUT_CYC,
	parameter int WD_FB_CYC   = WD_FALLBACK_CYC,
	parameter int LP_BASE_CYC = LP_PERIOD_BASE_CYC,
	parameter int SENSE_CYC   = SENSE_ON_CYC
) (
	input  wire logic  pclk,          // clock
	input  wire logic  presetn,       // async reset, low
	input  wire logic  ce,            // clock enable
	sbcw_if.dev        link,          // pins to host
	input  wire logic  vdd_low,       // output below reset_threshold
	input  wire logic  reg_overheat,  // regulator over-temperature
	input  wire logic  lin_overheat,  // transceiver over-temperature
	input  wire logic  txd_stuck,     // transmit stuck dominant
	input  wire logic  rxd_short,     // receive pin short
	input  wire logic  txd,           // transmit pin, 1 recessive
	input  wire logic  lin_rx,        // bus level, 0 dominant
	input  wire logic  wake_input,    // wake input level
	input  wire logic  amux_wake_sel, // wake input on multiplexer
	input  wire logic [1:0] wd_cfg,   // watchdog_config_pin sense
	output logic       reg_en_q,      // regulator enable
	output logic       lin_drv_en_q,  // LIN driver enable
	output logic [1:0] hs_on_q,       // high side switches
	output sbcw_state_t state_q       // operating mode
);
	sbcw_state_t state_d;
	logic [31:0] stretch_q, stretch_d, nreq_q, wd_q, lp_q, lin_q;
	logic        rst_oe_q, ack_q, irq_n_q, cs_prev_q, cs_arm_q;
	logic [7:0]  rdata_q, rd_val;
	logic        wake_en_q, receive_only_bit_q, wd_off_q, wd_fault_q;
	logic        l1_en_q, l1_ref_q, lin_fault_q, ot_flag_q;
	logic [1:0]  hs_q;
	logic [4:0]  tim_q;
	logic [3:0]  isr_q, isr_set;
	logic        filt_low, ext_low, acc, wr, rd, mode_wr;
	logic        lp, forced, cyclic, lp_end, l1_wake, force_wake;
	logic        lin_wake, lp_wake, cs_rise, wd_fail, nreq_to, int_rst;
	logic        lin_fault_now;
	logic [31:0] wd_to, lp_per;

	sbcw_glitch_filter #(.FILT_CYC(RST_FILTER_CYC)) u_rst_filt (
		.pclk       (pclk),
		.presetn    (presetn),
		.ce         (ce),
		.raw_low    (~link.rst_i & ~rst_oe_q),
		.filt_low_q (filt_low)
	);

	assign link.dev_rst_o  = 1'b0;
	assign link.dev_rst_oe = rst_oe_q;
	assign link.irq_n      = irq_n_q;
	assign link.rdata      = rdata_q;
	assign link.ack        = ack_q;

	// own low is not external
	assign ext_low = filt_low & ~rst_oe_q;
	assign acc     = link.req & ~ack_q;
	assign wr      = acc & link.we;
	assign rd      = acc & ~link.we;
	assign mode_wr = wr && link.addr == REG_MODE_CTRL;
	assign lp      = state_q == ST_STOP || state_q == ST_SLEEP;

	// R12: exclusive decode
	assign forced = tim_q[TIM_SEL_BIT] & (hs_q == 2'h0);
	assign cyclic = tim_q[TIM_SEL_BIT] & (hs_q != 2'h0);

	// R22: prescaled timebase
	assign wd_to  = sbcw_scale(wd_fault_q ? WD_FB_CYC : WD_RES_CYC,
		tim_q[TIM_PRESC_LSB +: 2]);
	assign lp_per = sbcw_scale(LP_BASE_CYC, tim_q[TIM_PERIOD_LSB +: 2]);
	assign lp_end = lp && lp_q >= lp_per - 32'd1;

	// R19: closed half or overflow fails
	assign wd_fail = state_q == ST_NORMAL && !wd_off_q &&
		((mode_wr && wd_q < (wd_to >> 1)) || wd_q >= wd_to - 32'd1);
	// R22: request mode timeout
	assign nreq_to = state_q == ST_NREQ && nreq_q >= 32'(NREQ_CYC - 1);
	// R03: undervoltage; R05: watchdog failure
	assign int_rst = (vdd_low && state_q != ST_SLEEP) || wd_fail ||
		nreq_to;

	// R09: direct wake; R10: gated at entry; R11: sampled per period
	assign l1_wake = lp & l1_en_q & (wake_input != l1_ref_q) &
		(~cyclic | lp_end);
	// R14: forced wake after one period
	assign force_wake = lp & forced & lp_end;
	// R16: long dominant then recessive; R17: blocked in stop
	assign lin_wake = lp && lin_rx && lin_q >= 32'(WAKE_PULSE_MIN_CYC) &&
		!(state_q == ST_STOP && receive_only_bit_q);
	assign lp_wake = l1_wake | force_wake | lin_wake;
	// R15: rise in stop, not the one closing the stop command
	assign cs_rise = state_q == ST_STOP && cs_arm_q && link.cs_n &&
		!cs_prev_q;
	assign lin_fault_now = lin_overheat | txd_stuck | rxd_short;

	always_comb begin
		state_d   = state_q;
		stretch_d = stretch_q;
		if (state_q == ST_RESET) begin
			// R02: hold while cause lasts, then stretch
			if (vdd_low) begin
				stretch_d = 32'(STRETCH_CYC);
			end else if (ext_low) begin
				stretch_d = stretch_q;
			end else if (stretch_q != 32'd0) begin
				stretch_d = stretch_q - 32'd1;
			end else begin
				// R20: no request mode without watchdog
				state_d = wd_off_q ? ST_NORMAL : ST_NREQ;
			end
		end else if (int_rst) begin
			state_d   = ST_RESET;
			stretch_d = 32'(STRETCH_CYC);
		end else if (ext_low && state_q != ST_SLEEP) begin
			// R06: safe state; R07: no stretch; R18: stop wake
			state_d   = ST_RESET;
			stretch_d = 32'd0;
		end else begin
			case (state_q)
				ST_NREQ: begin
					// R23: normal mode command
					if (mode_wr && link.wdata[1:0] == MODE_NORMAL)
						state_d = ST_NORMAL;
				end
				ST_NORMAL: begin
					if (mode_wr && link.wdata[1:0] == MODE_SLEEP)
						state_d = ST_SLEEP;
					else if (mode_wr && link.wdata[1:0] == MODE_STOP)
						state_d = ST_STOP;
				end
				ST_STOP: begin
					if (lp_wake || cs_rise)
						state_d = ST_NREQ;
				end
				ST_SLEEP: begin
					// R08: sleep wake is a full reset
					if (lp_wake) begin
						state_d   = ST_RESET;
						stretch_d = 32'(STRETCH_CYC);
					end
				end
				default: state_d = ST_RESET;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q   <= ST_RESET;
			stretch_q <= 32'(STRETCH_CYC);
			rst_oe_q  <= 1'b1;
		end else if (ce) begin
			state_q   <= state_d;
			stretch_q <= stretch_d;
			// R02: drive pin low in reset while stretch runs or vdd_low
			rst_oe_q  <= state_d == ST_RESET &&
				(stretch_d != 32'd0 || vdd_low);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nreq_q <= 32'd0;
			wd_q   <= 32'd0;
		end else if (ce) begin
			nreq_q <= state_q == ST_NREQ ? nreq_q + 32'd1 : 32'd0;
			// R19: mode write clears watchdog
			if (state_q != ST_NORMAL || wd_off_q || mode_wr)
				wd_q <= 32'd0;
			else
				wd_q <= wd_q + 32'd1;
		end
	end

	// R20: config pin sampled only in reset; R21: fallback flagged
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wd_off_q   <= 1'b0;
			wd_fault_q <= 1'b0;
		end else if (ce && state_q == ST_RESET) begin
			wd_off_q   <= wd_cfg == WDCFG_GND;
			wd_fault_q <= wd_cfg == WDCFG_OPEN;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lp_q      <= 32'd0;
			lin_q     <= 32'd0;
			l1_en_q   <= 1'b0;
			l1_ref_q  <= 1'b0;
			cs_prev_q <= 1'b1;
			cs_arm_q  <= 1'b0;
			hs_on_q   <= 2'h0;
		end else if (ce) begin
			cs_prev_q <= link.cs_n;
			cs_arm_q  <= state_q == ST_STOP && (cs_arm_q || link.cs_n);
			lp_q  <= (!lp || lp_end) ? 32'd0 : lp_q + 32'd1;
			lin_q <= (!lp || lin_rx) ? 32'd0 :
				(lin_q >= 32'(WAKE_PULSE_MIN_CYC) ? lin_q : lin_q + 32'd1);
			// R10: multiplexer selection disables wake at entry
			if (!lp) begin
				l1_en_q  <= wake_en_q & ~amux_wake_sel;
				l1_ref_q <= wake_input;
			end else if (lp_end) begin
				l1_ref_q <= wake_input;
			end
			// R11: switches on in the sense window
			if (lp)
				hs_on_q <= hs_q & {2{cyclic &&
					lp_q + 32'(SENSE_CYC) >= lp_per}};
			else if (state_q == ST_RESET)
				hs_on_q <= 2'h0;
			else
				hs_on_q <= hs_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reg_en_q     <= 1'b1;
			lin_drv_en_q <= 1'b0;
			lin_fault_q  <= 1'b0;
			ot_flag_q    <= 1'b0;
		end else if (ce) begin
			// R04: overheat turns regulator off; R08: off in sleep
			reg_en_q <= state_d != ST_SLEEP && !reg_overheat;
			// R04: sticky flag, set beats read clear
			ot_flag_q <= reg_overheat | (ot_flag_q &
				~(rd && link.addr == REG_SUPPLY));
			// R01: clear fault and recessive transmit to resume
			lin_fault_q  <= lin_fault_now | (lin_fault_q & ~txd);
			lin_drv_en_q <= state_d == ST_NORMAL && !receive_only_bit_q &&
				!lin_fault_now && !lin_fault_q;
		end
	end

	// R08: stop wakes report; R15 and R18 set nothing
	always_comb begin
		isr_set = 4'h0;
		isr_set[ISR_WAKE_IN]  = l1_wake;
		isr_set[ISR_LIN_WAKE] = lin_wake;
		isr_set[ISR_TIMER]    = force_wake;
		isr_set[ISR_LIN_FAULT] = lin_fault_now & ~lin_fault_q &
			(state_q == ST_NORMAL || state_q == ST_NREQ);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			isr_q   <= 4'h0;
			irq_n_q <= 1'b1;
		end else if (ce) begin
			// R24: read clears, a new event wins
			isr_q <= isr_set | (isr_q &
				{4{!(rd && link.addr == REG_INT_SRC)}});
			// R24: low while pending, none under reset
			irq_n_q <= !(isr_q != 4'h0 && link.rst_i &&
				(state_q == ST_NREQ || state_q == ST_NORMAL ||
				state_q == ST_STOP));
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_en_q <= 1'b0;
			hs_q      <= HS_RST;
			tim_q     <= TIM_RST;
			receive_only_bit_q  <= 1'b0;
		end else if (ce && wr) begin
			case (link.addr)
				REG_WAKE_CTRL: wake_en_q <= link.wdata[0];
				REG_HS_CTRL:   hs_q      <= link.wdata[1:0];
				REG_TIM_CTRL:  tim_q     <= link.wdata[4:0];
				REG_LIN_CTRL:  receive_only_bit_q  <= link.wdata[0];
				default:       ;
			endcase
		end
	end

	always_comb begin
		rd_val = 8'h00;
		case (link.addr)
			REG_MODE_CTRL: rd_val = {3'h0, state_q};
			REG_WAKE_CTRL: rd_val = {7'h00, wake_en_q};
			// R09: live wake input level
			REG_WAKE_STAT: rd_val = {6'h00, l1_en_q, wake_input};
			REG_HS_CTRL:   rd_val = {6'h00, hs_q};
			REG_TIM_CTRL:  rd_val = {3'h0, tim_q};
			REG_LIN_CTRL:  rd_val = {7'h00, receive_only_bit_q};
			REG_WD_STAT:   rd_val = {6'h00, wd_fault_q, wd_off_q};
			REG_INT_SRC:   rd_val = {4'h0, isr_q};
			REG_SUPPLY:    rd_val = {6'h00, lin_fault_q, ot_flag_q};
			default:       rd_val = 8'h00;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_q   <= 1'b0;
			rdata_q <= 8'h00;
		end else if (ce) begin
			ack_q <= acc;
			if (acc)
				rdata_q <= rd_val;
		end
	end
endmodule : sbcw_device

// ### hdl/sbcw_host.sv
/* Host end: APB registers that run link accesses and the reset line.
   Assumes the APB master shares pclk. */
module sbcw_host import sbcw_pkg::*; (
	input  wire logic        pclk,      // clock
	input  wire logic        presetn,   // async reset, low
	input  wire logic        ce,        // clock enable
	input  wire logic        psel,      // APB select
	input  wire logic        penable,   // APB enable
	input  wire logic        pwrite,    // APB direction
	input  wire logic [11:0] paddr,     // APB byte address
	input  wire logic [31:0] pwdata,    // APB write data
	output logic [31:0]      prdata_q,  // APB read data
	output logic             pready_q,  // APB ready
	output logic             pslverr_q, // APB error
	sbcw_if.host             link       // pins to device
);
	logic       req_q, we_q, busy_q, done_q, drive_rst_q;
	logic [3:0] addr_q;
	logic [7:0] wdata_q, rdata_q;
	logic       setup, access;
	logic [31:0] rd_val;
	logic        mapped;

	assign link.req         = req_q;
	assign link.we          = we_q;
	assign link.addr        = addr_q;
	assign link.wdata       = wdata_q;
	assign link.cs_n        = ~req_q;
	assign link.host_rst_o  = 1'b0;
	// R06: software-held external reset
	assign link.host_rst_oe = drive_rst_q;

	assign setup  = psel & ~penable & ~pready_q;
	assign access = psel & penable & pready_q;

	always_comb begin
		rd_val = 32'h0000_0000;
		mapped = 1'b1;
		case (paddr)
			HOST_CMD:    rd_val = {23'h00_0000, we_q, 4'h0, addr_q};
			HOST_WDATA:  rd_val = {24'h00_0000, wdata_q};
			HOST_RDATA:  rd_val = {24'h00_0000, rdata_q};
			HOST_STATUS: rd_val = {28'h000_0000, ~link.rst_i,
				~link.irq_n, done_q, busy_q};
			HOST_CTRL:   rd_val = {31'h0000_0000, drive_rst_q};
			default:     mapped = 1'b0;
		endcase
	end

	// one access cycle, answer staged in setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else if (ce) begin
			pready_q  <= setup;
			pslverr_q <= setup & ~mapped;
			if (setup)
				prdata_q <= pwrite ? 32'h0000_0000 : rd_val;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_q       <= 1'b0;
			we_q        <= 1'b0;
			addr_q      <= 4'h0;
			wdata_q     <= 8'h00;
			rdata_q     <= 8'h00;
			busy_q      <= 1'b0;
			done_q      <= 1'b0;
			drive_rst_q <= 1'b0;
		end else if (ce) begin
			if (req_q && link.ack) begin
				req_q   <= 1'b0;
				busy_q  <= 1'b0;
				done_q  <= 1'b1;
				rdata_q <= link.rdata;
			end
			// command fields frozen while a transfer runs
			if (access && pwrite && !busy_q) begin
				case (paddr)
					HOST_CMD: begin
						addr_q <= pwdata[3:0];
						we_q   <= pwdata[CMD_WE_BIT];
						if (pwdata[CMD_GO_BIT]) begin
							req_q  <= 1'b1;
							busy_q <= 1'b1;
							done_q <= 1'b0;
						end
					end
					HOST_WDATA: wdata_q <= pwdata[7:0];
					default:    ;
				endcase
			end
			if (access && pwrite && paddr == HOST_CTRL)
				drive_rst_q <= pwdata[0];
		end
	end
endmodule : sbcw_host

// ### verification/sbcw_monitor.sv
/* Link checker: handshake, reset line and interrupt timing.
   Assumes one pclk domain and an active-low async presetn. */
module sbcw_monitor import sbcw_pkg::*; #(
	parameter int STRETCH_CYC = RST_STRETCH_CYC
) (
	input wire logic       pclk,        // clock
	input wire logic       presetn,     // reset, low
	input wire logic       dev_rst_oe,  // device pulls reset
	input wire logic       host_rst_oe, // host pulls reset
	input wire logic       rst_i,       // reset line level
	input wire logic       irq_n,       // interrupt, low
	input wire logic       cs_n,        // chip select, low
	input wire logic       req,         // access request
	input wire logic       we,          // write access
	input wire logic [3:0] addr,        // register index
	input wire logic       ack          // access answer
);
	logic [15:0] run_q;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// cycles of the current device-driven low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) run_q <= '0;
		else run_q <= dev_rst_oe ? run_q + 16'h1 : 16'h0;
	end

	chk_ack_next: assert property (req && !ack |=> ack)
		else $error("ack missing one cycle after request");
	chk_ack_pulse: assert property (ack |=> !ack)
		else $error("ack longer than one cycle");
	chk_req_hold: assert property (req && !ack |=>
		req && $stable(addr) && $stable(we))
		else $error("request changed before ack");
	chk_cs_rise: assert property (ack |=> !req && cs_n)
		else $error("request not released after ack");
	// irq may only rise around an access or under reset
	chk_irq_hold: assert property (!irq_n && !req && !$past(ack) |=>
		!irq_n || !rst_i)
		else $error("irq released without source read");
	chk_stretch_min: assert property ($fell(dev_rst_oe) |->
		run_q >= 16'(STRETCH_CYC - 1))
		else $error("reset stretch too short");
	chk_stretch_start: assert property ($rose(presetn) |->
		dev_rst_oe [*8])
		else $error("reset pin released right after reset");
	chk_no_ext_stretch: assert property ($fell(host_rst_oe) &&
		!dev_rst_oe |=> !dev_rst_oe [*4])
		else $error("stretch added after external reset");

	cov_write: cover property (ack && we);
	cov_irq: cover property ($fell(irq_n));
	cov_ext: cover property ($fell(host_rst_oe) && !dev_rst_oe);
endmodule : sbcw_monitor

// ### verification/sbcw_tb.sv
/* Bench joining device and host ends through the link interface.
   Assumes nothing outside: it makes pclk, presetn and all pins. */
module sbcw_tb import sbcw_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int STR = 20;
	localparam int WDR = 100;
	localparam int LPB = 64;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        ce = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        vdd_low = 1'b0;
	logic        reg_ot = 1'b0;
	logic        lin_ot = 1'b0;
	logic        tie0 = 1'b0;
	logic        txd = 1'b1;
	logic        lin_rx = 1'b1;
	logic        wake_in = 1'b0;
	logic [1:0]  wd_cfg = WDCFG_RES;
	logic        reg_en;
	logic        lin_en;
	logic [1:0]  hs_on;
	sbcw_state_t state;
	logic [31:0] rd;
	logic        serr;
	logic [7:0]  q;
	int          errors = 0;
	int          n_checks = 0;

	always #20 pclk = ~pclk;

	sbcw_if i_sbcw_if ();
	sbcw_host i_sbcw_host (.pclk(pclk), .presetn(presetn), .ce(ce),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata_q(prdata), .pready_q(pready),
		.pslverr_q(pslverr), .link(i_sbcw_if));
	sbcw_device #(.STRETCH_CYC(STR), .NREQ_CYC(200), .WD_RES_CYC(WDR),
		.WD_FB_CYC(150), .LP_BASE_CYC(LPB), .SENSE_CYC(8))
		i_sbcw_device (.pclk(pclk), .presetn(presetn), .ce(ce),
		.link(i_sbcw_if), .vdd_low(vdd_low), .reg_overheat(reg_ot),
		.lin_overheat(lin_ot), .txd_stuck(tie0), .rxd_short(tie0),
		.txd(txd), .lin_rx(lin_rx), .wake_input(wake_in),
		.amux_wake_sel(tie0), .wd_cfg(wd_cfg), .reg_en_q(reg_en),
		.lin_drv_en_q(lin_en), .hs_on_q(hs_on), .state_q(state));
	sbcw_monitor #(.STRETCH_CYC(STR)) i_sbcw_monitor (.pclk(pclk),
		.presetn(presetn), .dev_rst_oe(i_sbcw_if.dev_rst_oe),
		.host_rst_oe(i_sbcw_if.host_rst_oe), .rst_i(i_sbcw_if.rst_i),
		.irq_n(i_sbcw_if.irq_n), .cs_n(i_sbcw_if.cs_n),
		.req(i_sbcw_if.req), .we(i_sbcw_if.we), .addr(i_sbcw_if.addr),
		.ack(i_sbcw_if.ack));

	task automatic report_and_stop;
		if (errors == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : report_and_stop

	task automatic ck(input string nm, input logic [31:0] s, e);
		n_checks++;
		if (s !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask : ck

	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
		rd = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// one link access, then the read word fetched into q
	task automatic acc(input logic w, input logic [3:0] i,
		input logic [7:0] d);
		int n = 0;
		apb(1'b1, HOST_WDATA, {24'h0, d});
		apb(1'b1, HOST_CMD, {1'b1, 22'h0, w, 4'h0, i});
		do begin
			apb(1'b0, HOST_STATUS, 32'h0);
			n++;
		end while (rd[1:0] !== 2'b10 && n < 20);
		apb(1'b0, HOST_RDATA, 32'h0);
		q = rd[7:0];
	endtask : acc

	task automatic wst(input sbcw_state_t s, input int lim);
		for (int n = 0; n < lim && state !== s; n++) @(posedge pclk);
		ck("state", state, s);
	endtask : wst

	task automatic wirq;
		for (int n = 0; n < 60 && i_sbcw_if.irq_n !== 1'b0; n++)
			@(posedge pclk);
		ck("irq_low", i_sbcw_if.irq_n, 1'b0);
	endtask : wirq

	task automatic lp(input int n);
		lin_rx <= 1'b0;
		repeat (n) @(posedge pclk);
		lin_rx <= 1'b1;
		repeat (4) @(posedge pclk);
	endtask : lp

	task automatic lpm(input logic [1:0] m, input sbcw_state_t s);
		acc(1'b1, REG_MODE_CTRL, 8'(m));
		ck("lp_mode", state, s);
	endtask : lpm

	task automatic gon;
		acc(1'b1, REG_MODE_CTRL, 8'(MODE_NORMAL));
		wst(ST_NORMAL, 4);
	endtask : gon

	task automatic ext;
		apb(1'b1, HOST_CTRL, 32'h1);
		repeat (60) @(posedge pclk);
		ck("ext", state, ST_RESET);
		apb(1'b1, HOST_CTRL, 32'h0);
	endtask : ext

	task automatic t_boot;
		apb(1'b0, HOST_STATUS, 32'h0);
		ck("pin_low", rd[3], 1'b1);
		apb(1'b0, 12'hff0, 32'h0);
		ck("unmapped", {serr, rd[30:0]}, 32'h8000_0000);
		wst(ST_NREQ, STR + 10);
	endtask : t_boot

	task automatic t_wd;
		gon;
		acc(1'b1, REG_MODE_CTRL, 8'(MODE_NORMAL));
		wst(ST_RESET, 4);
		wst(ST_NREQ, STR + 10);
		gon;
		repeat (WDR / 2) @(posedge pclk);
		acc(1'b1, REG_MODE_CTRL, 8'(MODE_NORMAL));
		ck("clear", state, ST_NORMAL);
		wst(ST_RESET, WDR + 4);
		wst(ST_NREQ, STR + 10);
		wst(ST_RESET, 210);
	endtask : t_wd

	task automatic t_ext;
		wst(ST_NREQ, STR + 10);
		wd_cfg <= WDCFG_GND;
		ext;
		apb(1'b0, HOST_STATUS, 32'h0);
		ck("no_stretch", rd[3], 1'b0);
		ck("wd_off", state, ST_NORMAL);
		acc(1'b0, REG_WD_STAT, 8'h0);
		ck("wd_off_bit", q[0], 1'b1);
		vdd_low <= 1'b1;
		repeat (3) @(posedge pclk);
		ck("vdd_rst", {state, i_sbcw_if.rst_i}, {ST_RESET, 1'b0});
		vdd_low <= 1'b0;
		wst(ST_NORMAL, STR + 10);
	endtask : t_ext

	task automatic t_lin;
		ck("lin_on", lin_en, 1'b1);
		lin_ot <= 1'b1;
		txd <= 1'b0;
		repeat (3) @(posedge pclk);
		ck("lin_off", lin_en, 1'b0);
		lin_ot <= 1'b0;
		repeat (3) @(posedge pclk);
		ck("lin_hold", lin_en, 1'b0);
		txd <= 1'b1;
		repeat (3) @(posedge pclk);
		ck("lin_back", lin_en, 1'b1);
		ck("fault_irq", i_sbcw_if.irq_n, 1'b0);
		acc(1'b0, REG_INT_SRC, 8'h0);
		ck("isr_fault", q[3], 1'b1);
		ck("irq_clr", i_sbcw_if.irq_n, 1'b1);
	endtask : t_lin

	task automatic t_stop;
		lpm(MODE_STOP, ST_STOP);
		acc(1'b0, REG_INT_SRC, 8'h0);
		ck("cs_wake", {state !== ST_STOP, q}, 9'h100);
		ck("cs_irq", i_sbcw_if.irq_n, 1'b1);
		gon;
		acc(1'b1, REG_WAKE_CTRL, 8'h1);
		acc(1'b0, REG_WAKE_STAT, 8'h0);
		ck("wake_stat", q[1:0], 2'b10);
		lpm(MODE_STOP, ST_STOP);
		wake_in <= 1'b1;
		wirq;
		acc(1'b0, REG_INT_SRC, 8'h0);
		ck("isr_wake", q[0], 1'b1);
		ck("irq_clr", i_sbcw_if.irq_n, 1'b1);
		gon;
		lpm(MODE_STOP, ST_STOP);
		ext;
		wst(ST_NORMAL, 6);
		ck("rst_irq", i_sbcw_if.irq_n, 1'b1);
	endtask : t_stop

	task automatic t_linw;
		lpm(MODE_STOP, ST_STOP);
		lp(100);
		ck("lin_short", state, ST_STOP);
		lp(1300);
		wirq;
		acc(1'b0, REG_INT_SRC, 8'h0);
		ck("isr_lin", q[1], 1'b1);
		gon;
		acc(1'b1, REG_LIN_CTRL, 8'h1);
		lpm(MODE_STOP, ST_STOP);
		lp(1300);
		ck("rx_only", state, ST_STOP);
		acc(1'b0, REG_INT_SRC, 8'h0);
		ck("rx_only_isr", q[1], 1'b0);
		gon;
	endtask : t_linw

	task automatic t_sleep;
		acc(1'b1, REG_TIM_CTRL, 8'h10);
		lpm(MODE_SLEEP, ST_SLEEP);
		ck("reg_off", reg_en, 1'b0);
		wst(ST_RESET, LPB + 8);
		@(posedge pclk);
		ck("reg_on", reg_en, 1'b1);
		wst(ST_NORMAL, STR + 10);
		acc(1'b0, REG_INT_SRC, 8'h0);
		ck("isr_timer", q[2], 1'b1);
	endtask : t_sleep

	task automatic t_cyc;
		acc(1'b1, REG_HS_CTRL, 8'h1);
		lpm(MODE_STOP, ST_STOP);
		for (int n = 0; n < 6 && hs_on !== 2'b00; n++) @(posedge pclk);
		for (int n = 0; n < LPB + 8 && hs_on === 2'b00; n++)
			@(posedge pclk);
		ck("sense_on", hs_on, 2'b01);
		repeat (12) @(posedge pclk);
		ck("not_forced", state, ST_STOP);
		acc(1'b0, REG_INT_SRC, 8'h0);
		gon;
		reg_ot <= 1'b1;
		repeat (3) @(posedge pclk);
		ck("reg_ot", reg_en, 1'b0);
		reg_ot <= 1'b0;
		acc(1'b0, REG_SUPPLY, 8'h0);
		ck("ot_flag", q[0], 1'b1);
	endtask : t_cyc

	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_boot;
		t_wd;
		t_ext;
		t_lin;
		t_stop;
		t_linw;
		t_sleep;
		t_cyc;
		report_and_stop;
	end

	// longest path is the two long bus pulses, well under this
	initial begin
		repeat (20000) @(posedge pclk);
		errors++;
		report_and_stop;
	end
endmodule : sbcw_tb
